// >>> dv/apb_host.sv
// partner model: host processor issuing apb transfers
`default_nettype none

module apb_host (
    // clock
    input wire logic         clock,
    // apb master signals
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // one transfer: setup, access until pready, then release with scrambled lines
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
        if (pready !== 1'b1) begin
            buffer_event_and_error_counters_test.n_errors++;
            buffer_event_and_error_counters_test.finish_test();
        end
    endtask : xfer
endmodule : apb_host

`default_nettype wire

// >>> dv/buffer_event_and_error_counters_test.sv
// testbench: register reads, event flags, counters and read races of the event block
`default_nettype none

module buffer_event_and_error_counters_test;
    timeunit 1ns;
    timeprecision 1ps;
    import buf_event_pkg::*;

    logic        clock, reset, ce, psel, penable, pwrite, pready, pslverr, irq, tx_abort;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    mac_events_t mac_events;
    line_state_t line_state;
    int          n_errors, samples_checked;

    // ------------------------------------------------------------
    // design, host model and clock
    // ------------------------------------------------------------
    buffer_event_and_error_counters i_buffer_event_and_error_counters (
        .clock(clock), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_events(mac_events), .line_state(line_state), .irq(irq), .tx_abort(tx_abort));
    apb_host host (
        .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic e;
        host.xfer(1'b0, a, 32'h0000_0000, v, e);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] r;
        logic e;
        host.xfer(1'b1, a, v, r, e);
    endtask : wr
    task automatic pulse(input logic [6:0] v);
        mac_events <= mac_events_t'(v);
        @(posedge clock);
        mac_events <= '0;
    endtask : pulse
    task automatic irq_after(input int cycles, input logic exp);
        repeat (cycles) @(posedge clock);
        check({31'h0, irq}, {31'h0, exp});
    endtask : irq_after
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic e;
        rd(12'h4B0, d); check(d, 32'h0000_000C);
        rd(12'h4C0, d); check(d, 32'h0000_0010);
        rd(12'h4C8, d); check(d, 32'h0000_0012);
        rd(12'h400, d); check(d, 32'h0000_000B);
        host.xfer(1'b0, 12'h4D0, 32'h0000_0000, d, e);
        check({31'h0, e}, 32'h0000_0001);
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_event_flags();
        logic [6:0] src [5] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h01};
        int         pos [5] = '{7, 8, 9, 10, 15};
        wr(12'h400, 32'h0000_8F80);
        for (int k = 0; k < 5; k++) begin
            pulse(src[k]);
            irq_after(2, 1'b1);
            rd(12'h4B0, d); check(d, 32'h0000_000C | (32'h1 << pos[k]));
            irq_after(2, 1'b0);
            rd(12'h4B0, d); check(d, 32'h0000_000C);
        end
        rd(12'h4C0, d); check(d, 32'h0000_0050);
        $display("test event_flags done");
    endtask : t_event_flags

    task automatic t_soft_irq();
        wr(12'h400, 32'h0000_0040);
        irq_after(2, 1'b1);
        rd(12'h400, d); check(d, 32'h0000_000B);
        rd(12'h4B0, d); check(d, 32'h0000_004C);
        rd(12'h4B0, d); check(d, 32'h0000_000C);
        $display("test soft_irq done");
    endtask : t_soft_irq

    task automatic t_early_rx();
        mac_events <= mac_events_t'(7'h05);
        @(posedge clock);
        mac_events <= mac_events_t'(7'h02);
        repeat (127) @(posedge clock);
        mac_events <= '0;
        rd(12'h4B0, d); check(d, 32'h0000_800C);
        pulse(7'h02);
        rd(12'h4B0, d); check(d, 32'h0000_080C);
        irq_after(1, 1'b0);
        $display("test early_rx done");
    endtask : t_early_rx

    task automatic t_counters();
        wr(12'h400, 32'h0000_1000);
        repeat (511) begin
            line_state <= 3'b101;
            @(posedge clock);
            line_state <= 3'b100;
            @(posedge clock);
        end
        irq_after(3, 1'b0);
        line_state <= 3'b110;
        irq_after(3, 1'b1);
        rd(12'h4C8, d); check(d, 32'h0000_8012);
        irq_after(2, 1'b0);
        rd(12'h4C8, d); check(d, 32'h0000_0012);
        // 1024 further collision rises walk the counter round to zero
        repeat (1024) begin
            line_state <= 3'b100;
            @(posedge clock);
            line_state <= 3'b101;
            @(posedge clock);
        end
        line_state <= 3'b000;
        rd(12'h4C8, d); check(d, 32'h0000_0012);
        wr(12'h400, 32'h0000_2000);
        mac_events <= mac_events_t'(7'h08);
        repeat (511) @(posedge clock);
        mac_events <= '0;
        irq_after(3, 1'b0);
        pulse(7'h08);
        irq_after(3, 1'b1);
        mac_events <= mac_events_t'(7'h08);
        repeat (512) @(posedge clock);
        mac_events <= '0;
        rd(12'h4C0, d); check(d, 32'h0000_0010);
        irq_after(2, 1'b0);
        rd(12'h4B0, d); check(d, 32'h0000_040C);
        $display("test counters done");
    endtask : t_counters

    task automatic t_read_race();
        fork
            rd(12'h4B0, d);
            begin
                repeat (2) @(posedge clock);
                mac_events <= mac_events_t'(7'h20);
                @(posedge clock);
                mac_events <= '0;
            end
        join
        check(d, 32'h0000_000C);
        irq_after(2, 1'b0);
        rd(12'h4B0, d); check(d, 32'h0000_010C);
        $display("test read_race done");
    endtask : t_read_race

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        mac_events = '0;
        line_state = '0;
        n_errors = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        t_reset_values();
        t_event_flags();
        t_soft_irq();
        t_early_rx();
        t_counters();
        t_read_race();
        finish_test();
    end
endmodule : buffer_event_and_error_counters_test

`default_nettype wire

// >>> dv/buffer_event_sva.sv
// checker: apb timing, identifier fields, abort pulse and soft interrupt of the event block
`default_nettype none

module buffer_event_sva
    import buf_event_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              reset,
    input wire logic              ce,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // mac side
    input wire mac_events_t       mac_events,
    input wire line_state_t       line_state,
    input wire logic              irq,
    input wire logic              tx_abort
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_access;
        psel && penable && !pready && ce;
    endsequence
    sequence s_read_done(a);
        pready && !pwrite && paddr == a;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ready_one_wait: assert property (s_access |=> pready)
        else $error("pready did not follow the access cycle");
    a_ready_single_pulse: assert property (pready && ce |=> !pready)
        else $error("pready held for more than one cycle");
    a_event_id_field: assert property (s_read_done(12'h4B0) |-> prdata[5:0] == BUF_EVENT_ID && prdata[31:16] == 16'h0000)
        else $error("event register identifier wrong");
    a_missed_id_field: assert property (s_read_done(12'h4C0) |-> prdata[5:0] == MISSED_CNT_ID)
        else $error("missed counter identifier wrong");
    a_coll_id_field: assert property (s_read_done(12'h4C8) |-> prdata[5:0] == COLL_CNT_ID)
        else $error("collision counter identifier wrong");
    a_unmapped_err: assert property (pready |-> pslverr == !(paddr == 12'h4B0 || paddr == 12'h4C0 ||
                                     paddr == 12'h4C8 || paddr == 12'h400))
        else $error("slave error does not match the address map");
    a_abort_after_starve: assert property (mac_events.tx_starved && ce |=> tx_abort)
        else $error("transmit abort missing after underrun");
    a_abort_has_cause: assert property (tx_abort |-> $past(mac_events.tx_starved))
        else $error("transmit abort without underrun");
    a_soft_irq_rise: assert property (s_access ##0 (pwrite && paddr == 12'h400 && pwdata[6]) |-> ##[1:3] irq)
        else $error("software interrupt request raised no interrupt");
endmodule : buffer_event_sva

bind buffer_event_and_error_counters buffer_event_sva #(.ADDR_W(ADDR_W)) i_buffer_event_sva (
    .clock(clock), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mac_events(mac_events), .line_state(line_state), .irq(irq), .tx_abort(tx_abort));

`default_nettype wire

// >>> verilog/buf_event_pkg.sv
// package: register map, field positions and carriers for the buffer event and error counter block
`default_nettype none

package buf_event_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] BUF_EVENT_IDX   = 12'h012C;
    localparam logic [11:0] MISSED_CNT_IDX  = 12'h0130;
    localparam logic [11:0] COLL_CNT_IDX    = 12'h0132;
    localparam logic [11:0] EVENT_CFG_IDX   = 12'h0100;

    // ------------------------------------------------------------
    // fixed identifier patterns in bits 5:0
    // ------------------------------------------------------------
    localparam logic [5:0]  BUF_EVENT_ID    = 6'h0C;
    localparam logic [5:0]  MISSED_CNT_ID   = 6'h10;
    localparam logic [5:0]  COLL_CNT_ID     = 6'h12;
    localparam logic [5:0]  EVENT_CFG_ID    = 6'h0B;

    // ------------------------------------------------------------
    // bit positions shared by event flags and their enables
    // ------------------------------------------------------------
    localparam int SOFT_IRQ_BIT      = 6;
    localparam int DMA_DONE_BIT      = 7;
    localparam int TX_READY_BIT      = 8;
    localparam int TX_STARVED_BIT    = 9;
    localparam int RX_LOST_BIT       = 10;
    localparam int EARLY_RX_BIT      = 11;
    localparam int COLL_MID_BIT      = 12;
    localparam int MISSED_MID_BIT    = 13;
    localparam int ADDR_MATCH_BIT    = 15;

    // ------------------------------------------------------------
    // masks, counter layout and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] EVENT_MASK      = 16'h8FC0;
    localparam logic [15:0] CFG_WRITE_MASK  = 16'hBF80;
    localparam logic [15:0] EVENT_CFG_RESET = 16'h0000;
    localparam int          COUNT_LSB       = 6;
    localparam int          COUNT_W         = 10;
    localparam logic [7:0]  EARLY_RX_BYTES  = 8'h80;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic dma_frame_done;
        logic tx_accept_ready;
        logic tx_starved;
        logic rx_frame_lost;
        logic rx_frame_start;
        logic rx_byte;
        logic addr_match;
    } mac_events_t;

    typedef struct packed {
        logic tx_active;
        logic tp_rx_active;
        logic attachment_collision_input;
    } line_state_t;

    // byte address of a register index
    function automatic logic [11:0] byte_addr(input logic [11:0] idx);
        byte_addr = {idx[9:0], 2'b00};
    endfunction : byte_addr

endpackage : buf_event_pkg

`default_nettype wire

// >>> verilog/buffer_event_and_error_counters.sv
// module: buffer event register, missed frame and collision counters behind an APB slave
//
// How it works
// - event register reads identifier 001100 in bits 5:0.
// - a software interrupt request sets the soft interrupt flag.
// - slave DMA moving received frames sets the DMA done flag, interrupts if enabled.
// - readiness to accept a transmit frame sets its flag, interrupts if enabled.
// - running out of transmit data sets the starved flag, interrupts if enabled.
// - frames lost to slow buffer unloading set the lost flag, interrupts if enabled.
// - 128 received bytes of a frame set the early receive flag.
// - passing the address filter sets the match flag, before the early flag.
// - reading the event register returns all flags then clears them.
// - missed counter sits in bits 15:6, counts frames lost for buffer space.
// - missed counter stepping 1FFh to 200h interrupts when enabled.
// - missed counter wraps to zero after 3FFh; host reads it before.
// - reading the missed counter returns it then clears it.
// - missed counter register reads identifier 010000 in bits 5:0.
// - collision counter in bits 15:6 counts collision activity during transmit.
// - collision counter stepping 1FFh to 200h interrupts when enabled.
// - collision counter wraps to zero after 3FFh; host reads it before.
// - reading the collision counter returns it then clears it.
// - collision counter register reads identifier 010010 in bits 5:0.
// - after a transmit underrun the frame is abandoned; host must rebid.
// - each written soft interrupt request produces exactly one event.
//
// Register access over APB is this design's own decision.
`default_nettype none

module buffer_event_and_error_counters
    import buf_event_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock, reset and clock enable
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              ce,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // mac engine events and line state
    input  wire mac_events_t       mac_events,
    input  wire line_state_t       line_state,
    // outputs to the system and transmit engine
    output logic                   irq,
    output logic                   tx_abort
);

    // ------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------
    logic        access;
    logic        rd_access;
    logic        wr_access;
    logic        hit_event;
    logic        hit_missed;
    logic        hit_coll;
    logic        hit_cfg;
    logic        hit_any;

    // a request acts once, in the access cycle before pready is shown
    assign access     = psel && penable && !pready;
    assign rd_access  = access && !pwrite;
    assign wr_access  = access && pwrite;
    assign hit_event  = paddr == ADDR_W'(byte_addr(BUF_EVENT_IDX));
    assign hit_missed = paddr == ADDR_W'(byte_addr(MISSED_CNT_IDX));
    assign hit_coll   = paddr == ADDR_W'(byte_addr(COLL_CNT_IDX));
    assign hit_cfg    = paddr == ADDR_W'(byte_addr(EVENT_CFG_IDX));
    assign hit_any    = hit_event || hit_missed || hit_coll || hit_cfg;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]        event_reg;
    logic [15:0]        event_next;
    logic [15:0]        event_set;
    logic [15:0]        enable_reg;
    logic [7:0]         rx_bytes_reg;
    logic               early_done_reg;
    logic               coll_line_reg;
    logic               coll_line;
    logic               coll_inc;
    logic               early_hit;
    logic [COUNT_W-1:0] missed_count;
    logic [COUNT_W-1:0] coll_count;
    logic               missed_mid;
    logic               coll_mid;
    logic [15:0]        read_word;

    // ------------------------------------------------------------
    // enable configuration register
    // ------------------------------------------------------------
    // software writes the enables; bit 6 is a request that is never stored
    always_ff @(posedge clock) begin
        if (reset) begin
            enable_reg <= EVENT_CFG_RESET;
        end else if (ce) begin
            if (wr_access && hit_cfg) begin
                enable_reg <= pwdata[15:0] & CFG_WRITE_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // early receive byte counting
    // ------------------------------------------------------------
    // count bytes of the current frame and fire once at the threshold
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_bytes_reg   <= 8'h00;
            early_done_reg <= 1'b0;
        end else if (ce) begin
            if (mac_events.rx_frame_start) begin
                rx_bytes_reg   <= 8'h00;
                early_done_reg <= 1'b0;
            end else if (mac_events.rx_byte && !early_done_reg) begin
                rx_bytes_reg   <= rx_bytes_reg + 8'h01;
                early_done_reg <= early_hit;
            end
        end
    end

    assign early_hit = mac_events.rx_byte && !early_done_reg && !mac_events.rx_frame_start
                       && (rx_bytes_reg == EARLY_RX_BYTES - 8'h01);

    // ------------------------------------------------------------
    // collision detection during transmit
    // ------------------------------------------------------------
    assign coll_line = line_state.tp_rx_active || line_state.attachment_collision_input;
    assign coll_inc  = line_state.tx_active && coll_line && !coll_line_reg;

    // remember the previous collision line level for edge detection
    always_ff @(posedge clock) begin
        if (reset) begin
            coll_line_reg <= 1'b0;
        end else if (ce) begin
            coll_line_reg <= coll_line;
        end
    end

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    // collect this cycle's events at the bit of their enables
    always_comb begin
        event_set                 = 16'h0000;
        event_set[SOFT_IRQ_BIT]   = wr_access && hit_cfg && pwdata[SOFT_IRQ_BIT];
        event_set[DMA_DONE_BIT]   = mac_events.dma_frame_done;
        event_set[TX_READY_BIT]   = mac_events.tx_accept_ready;
        event_set[TX_STARVED_BIT] = mac_events.tx_starved;
        event_set[RX_LOST_BIT]    = mac_events.rx_frame_lost;
        event_set[EARLY_RX_BIT]   = early_hit;
        event_set[ADDR_MATCH_BIT] = mac_events.addr_match;
    end

    // a read clears, but an event in the same cycle survives it
    always_comb begin
        if (rd_access && hit_event) begin
            event_next = event_set & EVENT_MASK;
        end else begin
            event_next = (event_reg | event_set) & EVENT_MASK;
        end
    end

    // hold the flags
    always_ff @(posedge clock) begin
        if (reset) begin
            event_reg <= 16'h0000;
        end else if (ce) begin
            event_reg <= event_next;
        end
    end

    // ------------------------------------------------------------
    // error counters
    // ------------------------------------------------------------
    // missed frames: one per frame lost for lack of buffer space
    counter_midpoint #(
        .WIDTH    (COUNT_W)
    ) u_missed (
        .clock    (clock),
        .reset    (reset),
        .ce       (ce),
        .inc      (mac_events.rx_frame_lost),
        .clear    (rd_access && hit_missed),
        .count    (missed_count),
        .midpoint (missed_mid)
    );

    // collisions: one per rise of collision activity while transmitting
    counter_midpoint #(
        .WIDTH    (COUNT_W)
    ) u_coll (
        .clock    (clock),
        .reset    (reset),
        .ce       (ce),
        .inc      (coll_inc),
        .clear    (rd_access && hit_coll),
        .count    (coll_count),
        .midpoint (coll_mid)
    );

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    // each register word carries its identifier in the low six bits
    always_comb begin
        read_word = 16'h0000;
        if (hit_event) begin
            read_word = {event_reg[15:6], BUF_EVENT_ID};
        end else if (hit_missed) begin
            read_word = {missed_count, MISSED_CNT_ID};
        end else if (hit_coll) begin
            read_word = {coll_count, COLL_CNT_ID};
        end else if (hit_cfg) begin
            read_word = {enable_reg[15:6], EVENT_CFG_ID};
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    // one wait state: data, ready and error are registered together
    always_ff @(posedge clock) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= access;
            pslverr <= access && !hit_any;
            if (rd_access) begin
                prdata <= {16'h0000, read_word};
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    // any enabled flag or midpoint raises the request
    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= (|(event_reg & enable_reg & EVENT_MASK))
                   || (missed_mid && enable_reg[MISSED_MID_BIT])
                   || (coll_mid && enable_reg[COLL_MID_BIT])
                   || event_reg[SOFT_IRQ_BIT];
        end
    end

    // ------------------------------------------------------------
    // transmit abandon on underrun
    // ------------------------------------------------------------
    // one-cycle pulse telling the transmit engine to drop the frame
    always_ff @(posedge clock) begin
        if (reset) begin
            tx_abort <= 1'b0;
        end else if (ce) begin
            tx_abort <= mac_events.tx_starved;
        end
    end

endmodule : buffer_event_and_error_counters

`default_nettype wire

// >>> verilog/counter_midpoint.sv
// module: read-clear wrapping counter with sticky midpoint flag
`default_nettype none

module counter_midpoint
    import buf_event_pkg::*;
#(
    parameter int WIDTH = 10
) (
    // clock and control
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             ce,
    // count and clear
    input  wire logic             inc,
    input  wire logic             clear,
    // state
    output logic [WIDTH-1:0]      count,
    output logic                  midpoint
);

    localparam logic [WIDTH-1:0] HALF_MINUS_ONE = {1'b0, {(WIDTH-1){1'b1}}};
    localparam logic [WIDTH-1:0] ONE            = {{(WIDTH-1){1'b0}}, 1'b1};

    // ------------------------------------------------------------
    // count: wraps after all ones, a clearing read keeps a same-cycle step
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            count <= '0;
        end else if (ce) begin
            if (clear) begin
                count <= inc ? ONE : '0;
            end else if (inc) begin
                count <= count + ONE;
            end
        end
    end

    // midpoint: sticky on the step from half minus one to half
    always_ff @(posedge clock) begin
        if (reset) begin
            midpoint <= 1'b0;
        end else if (ce) begin
            if (inc && !clear && count == HALF_MINUS_ONE) begin
                midpoint <= 1'b1;
            end else if (clear) begin
                midpoint <= 1'b0;
            end
        end
    end

endmodule : counter_midpoint

`default_nettype wire
